// [core/rvcr_pkg.sv]
// constants for the regulator voltage configuration register bank
// assumes a byte-wide register port driven by the serial interface engine on clk
package rvcr_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] SLEW_RATE_SELECT_OFFSET = 8'h07;
	localparam logic [7:0] LINEAR_REG_PAIR_A_OFFSET = 8'h08;
	localparam logic [7:0] LINEAR_REG_PAIR_B_OFFSET = 8'h09;
	localparam logic [7:0] BUCK_ONE_VOLTAGE_OFFSET = 8'h0a;

	// ----------------------------------------------------------------
	// field layout
	// ----------------------------------------------------------------
	localparam int SLEW_CODE_LSB = 0;
	localparam int LOW_CODE_LSB = 0;
	localparam int HIGH_CODE_LSB = 4;
	localparam int BUCK_CODE_LSB = 0;
	localparam logic [7:0] SLEW_WRITABLE_MASK = 8'h07;
	localparam logic [7:0] PAIR_WRITABLE_MASK = 8'h77;
	localparam logic [7:0] BUCK_WRITABLE_MASK = 8'h3f;

	// ----------------------------------------------------------------
	// reset values and special slew codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SLEW_CODE_RESET = 3'h6;
	localparam logic [2:0] SLEW_CODE_IMMEDIATE = 3'h7;
	localparam logic [2:0] SLEW_CODE_FASTEST = 3'h6;
	localparam logic [7:0] PAIR_RESET = 8'h00;
	localparam logic [5:0] BUCK_CODE_RESET = 6'h00;

	// strap-selected defaults, indexed by {strap_pin_b, strap_pin_a}
	localparam logic [3:0][7:0] STRAP_PAIR_A_DEFAULT = {8'h55, 8'h44, 8'h22, 8'h11};
	localparam logic [3:0][7:0] STRAP_PAIR_B_DEFAULT = {8'h55, 8'h44, 8'h22, 8'h11};
	localparam logic [3:0][7:0] STRAP_BUCK_DEFAULT = {8'h3f, 8'h28, 8'h10, 8'h08};

	// ----------------------------------------------------------------
	// ramp timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_MHZ = 125;
	localparam int FINE_STEP_UV = 25000;
	localparam int FASTEST_RATE_UV_PER_US = 7200;
	localparam int FASTEST_STEP_CYCLES = FINE_STEP_UV * CLK_FREQ_MHZ / FASTEST_RATE_UV_PER_US;

endpackage

// [core/rvcr_regs.sv]
// register bank: slew select, linear regulator codes, first converter code
// assumes reset is the undervoltage lockout event, synchronous to clk
//
// Operation
// (R01) slew register: 3-bit code, reset 110
// (R02) slew codes double rate; 111 jumps immediately
// (R03) reg one code in pair A bits 2:0
// (R04) reg two code in pair A bits 6:4
// (R05) reg three code in pair B bits 2:0
// (R06) reg four code in pair B bits 6:4
// (R07) buck one six-bit code, bits 7:6 zero
// (R08) buck one default comes from strap pins
// (R09) all voltage defaults loaded from strap pins
// (R10) straps latched once at lockout release
// (R11) host writes override strap defaults
// (R12) buck two ramps one code per interval
// (R13) upper buck codes use double step size
// (R14) writes to reserved bits ignored
`timescale 1ns/1ps
`default_nettype none

module rvcr_regs #(
	parameter int FAST_STEP_CYCLES = rvcr_pkg::FASTEST_STEP_CYCLES
) (
	// clock and lockout reset
	input wire logic clk,
	input wire logic reset,
	// strapping pins
	input wire logic strap_pin_a,
	input wire logic strap_pin_b,
	// register port
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// second converter target from its select logic
	input wire logic [5:0] buck_two_target,
	// regulator codes
	output logic [2:0] linear_reg_one_code,
	output logic [2:0] linear_reg_two_code,
	output logic [2:0] linear_reg_three_code,
	output logic [2:0] linear_reg_four_code,
	output logic [5:0] buck_one_code,
	output logic [2:0] slew_code,
	output logic [5:0] buck_slewed_output,
	output logic buck_two_ramping
);

	// ----------------------------------------------------------------
	// strap synchroniser
	// ----------------------------------------------------------------
	logic [1:0] strap_meta_reg;
	logic [1:0] strap_sync_reg;

	// no reset here so the pins are already settled when lockout releases
	always_ff @(posedge clk) begin
		strap_meta_reg <= {strap_pin_b, strap_pin_a};
		strap_sync_reg <= strap_meta_reg;
	end

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic load_pending_reg, load_pending_next;
	logic [7:0] slew_reg, slew_next;
	logic [7:0] pair_a_reg, pair_a_next;
	logic [7:0] pair_b_reg, pair_b_next;
	logic [7:0] buck_reg, buck_next;
	logic [7:0] rdata_reg, rdata_next;
	logic host_wr;

	// writes are held off during the one-cycle strap load
	assign host_wr = reg_wr_en && !load_pending_reg;

	// next values of the register bank
	always_comb begin
		load_pending_next = 1'b0;
		slew_next = slew_reg;
		pair_a_next = pair_a_reg;
		pair_b_next = pair_b_reg;
		buck_next = buck_reg;
		rdata_next = 8'h00;
		if (load_pending_reg) begin
			pair_a_next = rvcr_pkg::STRAP_PAIR_A_DEFAULT[strap_sync_reg]; // [R09] [R10]
			pair_b_next = rvcr_pkg::STRAP_PAIR_B_DEFAULT[strap_sync_reg]; // [R09]
			buck_next = rvcr_pkg::STRAP_BUCK_DEFAULT[strap_sync_reg]; // [R08]
		end else if (host_wr) begin
			unique case (reg_addr)
				rvcr_pkg::SLEW_RATE_SELECT_OFFSET: begin
					slew_next = reg_wdata & rvcr_pkg::SLEW_WRITABLE_MASK; // [R01] [R14]
				end
				rvcr_pkg::LINEAR_REG_PAIR_A_OFFSET: begin
					pair_a_next = reg_wdata & rvcr_pkg::PAIR_WRITABLE_MASK; // [R03] [R04] [R11]
				end
				rvcr_pkg::LINEAR_REG_PAIR_B_OFFSET: begin
					pair_b_next = reg_wdata & rvcr_pkg::PAIR_WRITABLE_MASK; // [R05] [R06] [R11]
				end
				rvcr_pkg::BUCK_ONE_VOLTAGE_OFFSET: begin
					buck_next = reg_wdata & rvcr_pkg::BUCK_WRITABLE_MASK; // [R07] [R11] [R14]
				end
				default: begin
				end
			endcase
		end
		// unmapped offsets read as zero
		if (reg_rd_en) begin
			unique case (reg_addr)
				rvcr_pkg::SLEW_RATE_SELECT_OFFSET: rdata_next = slew_reg;
				rvcr_pkg::LINEAR_REG_PAIR_A_OFFSET: rdata_next = pair_a_reg;
				rvcr_pkg::LINEAR_REG_PAIR_B_OFFSET: rdata_next = pair_b_reg;
				rvcr_pkg::BUCK_ONE_VOLTAGE_OFFSET: rdata_next = buck_reg;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// lockout acts as the register reset
	always_ff @(posedge clk) begin
		if (reset) begin
			load_pending_reg <= 1'b1;
			slew_reg <= {5'h00, rvcr_pkg::SLEW_CODE_RESET}; // [R01]
			pair_a_reg <= rvcr_pkg::PAIR_RESET;
			pair_b_reg <= rvcr_pkg::PAIR_RESET;
			buck_reg <= {2'h0, rvcr_pkg::BUCK_CODE_RESET};
			rdata_reg <= 8'h00;
		end else begin
			load_pending_reg <= load_pending_next;
			slew_reg <= slew_next;
			pair_a_reg <= pair_a_next;
			pair_b_reg <= pair_b_next;
			buck_reg <= buck_next;
			rdata_reg <= rdata_next;
		end
	end

	// field outputs taken straight from the register flops
	assign reg_rdata = rdata_reg;
	assign slew_code = slew_reg[rvcr_pkg::SLEW_CODE_LSB +: 3];
	assign linear_reg_one_code = pair_a_reg[rvcr_pkg::LOW_CODE_LSB +: 3];
	assign linear_reg_two_code = pair_a_reg[rvcr_pkg::HIGH_CODE_LSB +: 3];
	assign linear_reg_three_code = pair_b_reg[rvcr_pkg::LOW_CODE_LSB +: 3];
	assign linear_reg_four_code = pair_b_reg[rvcr_pkg::HIGH_CODE_LSB +: 3];
	assign buck_one_code = buck_reg[rvcr_pkg::BUCK_CODE_LSB +: 6];

	// ----------------------------------------------------------------
	// second converter ramp
	// ----------------------------------------------------------------
	logic [5:0] ramp_code_reg, ramp_code_next;
	logic [16:0] ramp_cnt_reg, ramp_cnt_next;
	logic ramping_reg, ramping_next;
	logic [16:0] step_interval;
	logic [5:0] span_code;

	// each slower code halves the rate; the voltage gap of a step is set by the
	// upper code of the pair crossed: 25 mV up to 32, 50 mV up to 60, 100 mV above
	always_comb begin
		span_code = (ramp_code_reg < buck_two_target) ?
			ramp_code_reg + 6'h01 : ramp_code_reg;
		step_interval = 17'(FAST_STEP_CYCLES) << (rvcr_pkg::SLEW_CODE_FASTEST - slew_code); // [R02]
		if (span_code > 6'h3c) begin
			step_interval = step_interval << 2; // [R13]
		end else if (span_code > 6'h20) begin
			step_interval = step_interval << 1; // [R13]
		end
	end

	// jump to the target at the immediate code, else step toward it one code at a time
	always_comb begin
		ramp_code_next = ramp_code_reg;
		ramp_cnt_next = 17'h00000;
		if (slew_code == rvcr_pkg::SLEW_CODE_IMMEDIATE) begin
			ramp_code_next = buck_two_target; // [R02]
		end else if (ramp_code_reg != buck_two_target) begin
			if (ramp_cnt_reg >= step_interval - 17'h00001) begin
				ramp_code_next = (ramp_code_reg < buck_two_target) ?
					ramp_code_reg + 6'h01 : ramp_code_reg - 6'h01; // [R12]
			end else begin
				ramp_cnt_next = ramp_cnt_reg + 17'h00001;
			end
		end
		ramping_next = ramp_code_next != buck_two_target;
	end

	// ramp state starts at the lowest code and walks up after release
	always_ff @(posedge clk) begin
		if (reset) begin
			ramp_code_reg <= rvcr_pkg::BUCK_CODE_RESET;
			ramp_cnt_reg <= 17'h00000;
			ramping_reg <= 1'b0;
		end else begin
			ramp_code_reg <= ramp_code_next;
			ramp_cnt_reg <= ramp_cnt_next;
			ramping_reg <= ramping_next;
		end
	end

	assign buck_slewed_output = ramp_code_reg;
	assign buck_two_ramping = ramping_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_release;
		$fell(reset);
	endsequence

	sequence s_write(logic [7:0] off);
		!reset && host_wr && reg_addr == off;
	endsequence

	// a ramp move made by the counter, not a jump from the immediate code
	sequence s_ramp_move;
		$past(slew_code) != rvcr_pkg::SLEW_CODE_IMMEDIATE && !$stable(buck_slewed_output);
	endsequence

	// register port: reset value, write paths and reserved bits
	a_slew_reset: assert property (@(posedge clk) // [R01]
		reset |=> slew_code == rvcr_pkg::SLEW_CODE_RESET)
		else $error("slew code not 110 after lockout");

	a_slew_write: assert property (@(posedge clk) disable iff (reset) // [R01] [R14]
		s_write(rvcr_pkg::SLEW_RATE_SELECT_OFFSET)
		|=> slew_reg == {5'h00, $past(reg_wdata[2:0])})
		else $error("slew write not applied or reserved bits kept");

	a_slew_read_zero: assert property (@(posedge clk) disable iff (reset) // [R01]
		reg_rd_en && reg_addr == rvcr_pkg::SLEW_RATE_SELECT_OFFSET
		|=> reg_rdata[7:3] == 5'h00)
		else $error("slew reserved bits read nonzero");

	a_pair_rsvd_zero: assert property (@(posedge clk) disable iff (reset) // [R03] [R05]
		reg_rd_en && (reg_addr == 8'h08 || reg_addr == 8'h09)
		|=> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
		else $error("pair reserved bits read nonzero");

	// reserved bits must stay clear in the flops, whatever the host wrote
	a_pair_rsvd_held: assert property (@(posedge clk) disable iff (reset) // [R14]
		pair_a_reg[7] == 1'b0 && pair_a_reg[3] == 1'b0
		&& pair_b_reg[7] == 1'b0 && pair_b_reg[3] == 1'b0)
		else $error("pair reserved bit set");

	a_buck_rsvd_held: assert property (@(posedge clk) disable iff (reset) // [R07] [R14]
		buck_reg[7:6] == 2'h0)
		else $error("buck one reserved bits set");

	// strap defaults land one edge after lockout releases, then stay put
	a_strap_load: assert property (@(posedge clk) disable iff (reset) // [R08] [R09] [R10]
		s_release ##0 load_pending_reg
		|=> pair_a_reg == rvcr_pkg::STRAP_PAIR_A_DEFAULT[$past(strap_sync_reg)]
		&& pair_b_reg == rvcr_pkg::STRAP_PAIR_B_DEFAULT[$past(strap_sync_reg)]
		&& buck_reg == rvcr_pkg::STRAP_BUCK_DEFAULT[$past(strap_sync_reg)])
		else $error("strap defaults not loaded at release");

	a_strap_ignored: assert property (@(posedge clk) disable iff (reset) // [R10]
		!load_pending_reg && !reg_wr_en
		|=> $stable(pair_a_reg) && $stable(pair_b_reg) && $stable(buck_reg))
		else $error("code changed without a host write");

	a_pair_a_write: assert property (@(posedge clk) disable iff (reset) // [R03] [R04] [R11]
		s_write(rvcr_pkg::LINEAR_REG_PAIR_A_OFFSET)
		|=> linear_reg_one_code == $past(reg_wdata[2:0])
		&& linear_reg_two_code == $past(reg_wdata[6:4]))
		else $error("pair A write not applied");

	a_pair_b_write: assert property (@(posedge clk) disable iff (reset) // [R05] [R06] [R11]
		s_write(rvcr_pkg::LINEAR_REG_PAIR_B_OFFSET)
		|=> linear_reg_four_code == $past(reg_wdata[6:4])
		&& linear_reg_three_code == $past(reg_wdata[2:0]))
		else $error("pair B write not applied");

	a_buck_write: assert property (@(posedge clk) disable iff (reset) // [R07] [R11]
		s_write(rvcr_pkg::BUCK_ONE_VOLTAGE_OFFSET)
		|=> buck_one_code == $past(reg_wdata[5:0]))
		else $error("buck one write not applied");

	a_buck_read_zero: assert property (@(posedge clk) disable iff (reset) // [R07]
		reg_rd_en && reg_addr == rvcr_pkg::BUCK_ONE_VOLTAGE_OFFSET
		|=> reg_rdata[7:6] == 2'h0)
		else $error("buck one reserved bits read nonzero");

	// second converter ramp: jump, single steps, pacing and busy flag
	a_ramp_immediate: assert property (@(posedge clk) disable iff (reset) // [R02]
		slew_code == rvcr_pkg::SLEW_CODE_IMMEDIATE
		|=> buck_slewed_output == $past(buck_two_target))
		else $error("immediate code did not jump");

	a_ramp_single: assert property (@(posedge clk) disable iff (reset) // [R12]
		s_ramp_move
		|-> (buck_slewed_output - $past(buck_slewed_output) == 6'h01)
		|| ($past(buck_slewed_output) - buck_slewed_output == 6'h01))
		else $error("ramp moved more than one code");

	// the count starts at zero after each step, so one edge later it must read one
	a_ramp_wait: assert property (@(posedge clk) disable iff (reset) // [R12]
		slew_code == rvcr_pkg::SLEW_CODE_FASTEST && !ramp_code_reg[5]
		&& ramp_code_reg != buck_two_target && ramp_cnt_reg == 17'h00000
		&& $stable(buck_two_target)
		|=> ramp_code_reg == $past(ramp_code_reg) && ramp_cnt_reg == 17'h00001)
		else $error("ramp stepped too early");

	// at the fastest code a fine step needs the full base interval behind it
	a_ramp_paced: assert property (@(posedge clk) disable iff (reset) // [R02] [R12]
		s_ramp_move ##0 $past(slew_code) == rvcr_pkg::SLEW_CODE_FASTEST
		&& !$past(ramp_code_reg[5])
		|-> $past(ramp_cnt_reg) >= 17'(FAST_STEP_CYCLES - 1))
		else $error("ramp step before its interval ran out");

	// busy flag is forced low in lockout, so skip the first edge after it
	a_ramp_flag: assert property (@(posedge clk) disable iff (reset) // [R12]
		!$past(reset)
		|-> buck_two_ramping == (buck_slewed_output != $past(buck_two_target)))
		else $error("ramping flag disagrees with code and target");

endmodule

`default_nettype wire

// [tb/rvcr_host_model.sv]
// host model: stands in for the serial engine on the byte register port
// assumes clk is the bank clock; strobes move 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none

module rvcr_host_model (
	// clock
	input wire logic clk,
	// register port
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	// idle port; address and data invert on release so stale values never match
	initial begin
		reg_wr_en = 1'h0;
		reg_rd_en = 1'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// one write strobe per byte, held through the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_wr_en = 1'h1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1;
		reg_wr_en = 1'h0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	// read strobe; data stands for the one cycle after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		reg_rd_en = 1'h1;
		reg_addr = a;
		@(posedge clk);
		#1;
		reg_rd_en = 1'h0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule

`default_nettype wire

// [tb/rvcr_regs_tb_top.sv]
// testbench for the regulator voltage register bank
// assumes a short ramp interval of 2 cycles for simulation
`timescale 1ns/1ps
`default_nettype none

module rvcr_regs_tb_top;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic strap_pin_a = 1'h0;
	logic strap_pin_b = 1'h0;
	logic [5:0] buck_two_target = 6'h00;
	logic reg_wr_en;
	logic reg_rd_en;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [2:0] l1, l2, l3, l4, slew;
	logic [5:0] b1, bso;
	logic ramping;
	logic [7:0] rb;
	int error_cnt = 0;
	int n_tests = 0;
	int cycles = 0;
	// rows: offset, write data, expected readback (reserved bits and unmapped read as 0)
	logic [23:0] rows [10] = '{24'h07ff07, 24'h070000, 24'h08ff77, 24'h08a525, 24'h09ff77,
		24'h093a32, 24'h0aff3f, 24'h0ac101, 24'h0bff00, 24'h07fe06};

	always #4 clk = ~clk;

	rvcr_regs #(.FAST_STEP_CYCLES(2)) u_rvcr_regs (.clk(clk), .reset(reset),
		.strap_pin_a(strap_pin_a), .strap_pin_b(strap_pin_b), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .buck_two_target(buck_two_target),
		.linear_reg_one_code(l1), .linear_reg_two_code(l2), .linear_reg_three_code(l3),
		.linear_reg_four_code(l4), .buck_one_code(b1), .slew_code(slew),
		.buck_slewed_output(bso), .buck_two_ramping(ramping));

	rvcr_host_model u_rvcr_host_model (.clk(clk), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// output codes packed back into register layout
	function automatic logic [7:0] obs(input logic [7:0] a);
		case (a)
			8'h07: obs = {5'h00, slew};
			8'h08: obs = {1'h0, l2, 1'h0, l1};
			8'h09: obs = {1'h0, l4, 1'h0, l3};
			8'h0a: obs = {2'h0, b1};
			default: obs = 8'h00;
		endcase
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// lockout for 6 cycles, then let the strap load edge pass
	task automatic do_reset();
		@(posedge clk);
		#1;
		reset = 1'h1;
		repeat (6) @(posedge clk);
		#1;
		reset = 1'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// new target: output holds for hold cycles, then reaches it after more
	task automatic ramp(input logic [5:0] t, input int hold, input int more);
		logic [5:0] old;
		old = bso;
		buck_two_target = t;
		repeat (hold) @(posedge clk);
		#1;
		chk({2'h0, bso}, {2'h0, old});
		if (hold > 0) chk({7'h00, ramping}, 8'h01);
		repeat (more) @(posedge clk);
		#1;
		chk({2'h0, bso}, {2'h0, t});
		chk({7'h00, ramping}, 8'h00);
	endtask

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			error_cnt++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		do_reset();
		foreach (rows[k]) begin
			u_rvcr_host_model.wr(rows[k][23:16], rows[k][15:8]);
			chk(obs(rows[k][23:16]), rows[k][7:0]);
			u_rvcr_host_model.rd(rows[k][23:16], rb);
			chk(rb, rows[k][7:0]);
		end
		// interval 2 at fastest code, 128 at slowest
		ramp(6'h01, 1, 2);
		u_rvcr_host_model.wr(8'h07, 8'h00);
		ramp(6'h02, 127, 2);
		u_rvcr_host_model.wr(8'h07, 8'h07);
		ramp(6'h21, 0, 1);
		// above code 32 the step is doubled, so interval 4
		u_rvcr_host_model.wr(8'h07, 8'h06);
		ramp(6'h22, 3, 2);
		// the top codes are 100 mV apart, so interval 8
		u_rvcr_host_model.wr(8'h07, 8'h07);
		ramp(6'h3c, 0, 1);
		u_rvcr_host_model.wr(8'h07, 8'h06);
		ramp(6'h3d, 7, 2);
		u_rvcr_host_model.wr(8'h07, 8'h05);
		// each strap setting, pins flipped after the latch
		for (int i = 0; i < 4; i++) begin
			strap_pin_a = i[0];
			strap_pin_b = i[1];
			do_reset();
			strap_pin_a = ~i[0];
			strap_pin_b = ~i[1];
			u_rvcr_host_model.rd(8'h07, rb);
			chk(rb, 8'h06);
			u_rvcr_host_model.rd(8'h08, rb);
			chk(rb, rvcr_pkg::STRAP_PAIR_A_DEFAULT[i]);
			u_rvcr_host_model.rd(8'h09, rb);
			chk(rb, rvcr_pkg::STRAP_PAIR_B_DEFAULT[i]);
			u_rvcr_host_model.rd(8'h0a, rb);
			chk(rb, rvcr_pkg::STRAP_BUCK_DEFAULT[i]);
		end
		test_done();
	end
endmodule

`default_nettype wire
